// ---- src/prm_gen.v ----
// Once-per-second performance report message generator with APB control
`timescale 1ns/1ps
`include "prm_defs.vh"

// Functional notes
// R1 - Reports go out only in T1/J1 mode with extended superframe framing.
// R2 - With enable set, build a report every second, send on data-link slots.
// R3 - Count line violations, CRC-6, framing, severe framing errors and slips.
// R4 - Header: flag, address 001110 C/R 0, 00000001, fixed control value.
// R5 - Octets five to twelve are four identical status pairs.
// R6 - Send bit 1 first within each octet, octets one to fourteen.
// R7 - C/R, R, U1, U2 and LB copy the control register bits.
// R8 - The Nm and Ni positions carry a modulo-four counter.
// R9 - Event positions default to zero, set only when their condition holds.
// R10 - CRC-6 grades: one, two to five, six to ten.
// R11 - CRC-6 grades: to one hundred, to 319, above 320.
// R12 - SE and FE set on at least one event in the second.
// R13 - LV and SL set on at least one event in the second.
// R14 - Clear counters each second after capturing the previous results.
// R15 - Octets thirteen and fourteen carry the 16-bit frame check sequence.
module prm_gen #(
    parameter [24:0] SECOND_CYCLES = `PRM_SECOND_CYCLES
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output wire pready,
    output wire pslverr,
    output reg [31:0] prdata_q,
    input wire t1_mode,
    input wire esf_mode,
    input wire data_link_slot,
    input wire evt_line_viol,
    input wire evt_crc,
    input wire evt_frame_bit,
    input wire evt_severe_frame,
    input wire evt_slip,
    output wire dl_active,
    output reg dl_data_q
);

    localparam [24:0] SEC_LAST = SECOND_CYCLES - 25'h000_0001;

    // ****************************************************************
    // APB slave
    // ****************************************************************
    reg [5:0] ctrl_q;
    reg busy_q;
    reg [1:0] seq_q;
    reg [8:0] last_crc_q;
    wire hit_ctrl;
    wire hit_stat;
    wire mapped;

    assign hit_ctrl = (paddr == `PRM_CTRL_ADDR);
    assign hit_stat = (paddr == `PRM_STAT_ADDR);
    assign mapped = hit_ctrl | hit_stat;
    // Zero wait states; read data is registered in the setup cycle
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~mapped;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= `PRM_CTRL_RESET;
        end else if (psel && penable && pwrite && hit_ctrl) begin
            ctrl_q <= pwdata[5:0];
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            if (hit_ctrl) begin
                prdata_q <= {26'h000_0000, ctrl_q};
            end else if (hit_stat) begin
                prdata_q <= {20'h0_0000, seq_q, busy_q, last_crc_q};
            end else begin
                prdata_q <= 32'h0000_0000;
            end
        end
    end

    // ****************************************************************
    // One-second timebase and event counting
    // ****************************************************************
    reg [24:0] sec_cnt_q;
    wire sec_tick;
    wire [8:0] crc_count;
    wire [3:0] flags;

    assign sec_tick = (sec_cnt_q == SEC_LAST);

    // R2 second timebase
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sec_cnt_q <= 25'h000_0000;
        end else if (sec_tick) begin
            sec_cnt_q <= 25'h000_0000;
        end else begin
            sec_cnt_q <= sec_cnt_q + 25'h000_0001;
        end
    end

    // R14 counters clear on the tick that captures them
    prm_evt_count u_count (
        .pclk(pclk),
        .presetn(presetn),
        .clear(sec_tick),
        .evt_crc(evt_crc),
        .evt_flag({evt_slip, evt_severe_frame, evt_frame_bit, evt_line_viol}),
        .crc_count_q(crc_count),
        .flag_q(flags)
    );

    // ****************************************************************
    // Status octet contents
    // ****************************************************************
    reg g1;
    reg g2;
    reg g3;
    reg g4;
    reg g5;
    reg g6;
    wire lv;
    wire fe;
    wire se;
    wire sl;
    wire [7:0] odd_oct;
    wire [7:0] even_oct;
    wire [7:0] addr_oct;

    always @* begin
        // R9 grades default to zero
        g1 = 1'b0;
        g2 = 1'b0;
        g3 = 1'b0;
        g4 = 1'b0;
        g5 = 1'b0;
        g6 = 1'b0;
        // R10 low grades
        if (crc_count == `PRM_CRC_ONE) begin
            g1 = 1'b1;
        end else if (crc_count > `PRM_CRC_ONE && crc_count <= `PRM_CRC_FIVE) begin
            g2 = 1'b1;
        end else if (crc_count > `PRM_CRC_FIVE && crc_count <= `PRM_CRC_TEN) begin
            g3 = 1'b1;
        // R11 high grades; a count of exactly 320 sets none
        end else if (crc_count > `PRM_CRC_TEN && crc_count <= `PRM_CRC_HUNDRED) begin
            g4 = 1'b1;
        end else if (crc_count > `PRM_CRC_HUNDRED && crc_count <= `PRM_CRC_319) begin
            g5 = 1'b1;
        end else if (crc_count > `PRM_CRC_320) begin
            g6 = 1'b1;
        end
    end

    // R13 line violation and slip
    assign lv = flags[0];
    assign sl = flags[3];
    // R12 framing flags
    assign fe = flags[1];
    assign se = flags[2];

    // R5 status pair layout, bit 8 at the left
    // R7 software-programmed positions
    // R8 sequence count in the last two bits
    assign odd_oct = {g3, lv, g4, ctrl_q[`PRM_CTRL_U1_BIT], ctrl_q[`PRM_CTRL_U2_BIT],
                      g5, sl, g6};
    assign even_oct = {fe, se, ctrl_q[`PRM_CTRL_LB_BIT], g1, ctrl_q[`PRM_CTRL_R_BIT],
                       g2, seq_q[1], seq_q[0]};
    // R4 address octet with the command/response bit
    assign addr_oct = {`PRM_ADDR_HI, ctrl_q[`PRM_CTRL_CR_BIT], 1'b0};

    // ****************************************************************
    // Message build and serialisation
    // ****************************************************************
    reg [95:0] msg_q;
    reg [6:0] bit_q;
    wire mode_ok;
    wire start;
    wire consume;
    wire last_bit;
    wire [6:0] bit_next;
    wire in_tail;
    wire crc_step;
    wire [15:0] crc_d;
    wire [95:0] msg_init;

    // R1 only T1/J1 extended superframe
    assign mode_ok = t1_mode & esf_mode;
    // R2 build on the tick; a report still in flight makes this second skip
    assign start = sec_tick & ctrl_q[`PRM_CTRL_EN_BIT] & mode_ok & ~busy_q;
    assign consume = busy_q & data_link_slot & mode_ok;
    assign last_bit = (bit_q == `PRM_LAST_BIT);
    assign bit_next = bit_q + `PRM_BIT_ONE;
    assign in_tail = (bit_q >= `PRM_FCS_TAIL);
    // R15 covered span is octets two to twelve, flag excluded
    assign crc_step = consume & (bit_q >= `PRM_FCS_FIRST);
    assign dl_active = busy_q;

    // R4 header octets
    // R5 four identical pairs
    assign msg_init = {even_oct, odd_oct, even_oct, odd_oct,
                       even_oct, odd_oct, even_oct, odd_oct,
                       `PRM_CONTROL, `PRM_TEI, addr_oct, `PRM_FLAG};

    prm_fcs16 u_fcs (
        .pclk(pclk),
        .presetn(presetn),
        .init(start),
        .step(crc_step),
        .tail(in_tail),
        .din(dl_data_q),
        .crc_d(crc_d),
        .crc_q()
    );

    // R6 bit 1 first, octet 1 first
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy_q <= 1'b0;
            bit_q <= 7'h00;
            msg_q <= 96'h0;
            dl_data_q <= 1'b0;
        end else if (start) begin
            busy_q <= 1'b1;
            bit_q <= 7'h00;
            msg_q <= msg_init;
            dl_data_q <= msg_init[0];
        end else if (busy_q && !mode_ok) begin
            // Framing changed mid-report: abandon it rather than send garbage
            busy_q <= 1'b0;
            dl_data_q <= 1'b0;
        end else if (consume) begin
            bit_q <= bit_next;
            msg_q <= {1'b0, msg_q[95:1]};
            if (last_bit) begin
                busy_q <= 1'b0;
                dl_data_q <= 1'b0;
            end else if (bit_next >= `PRM_FCS_TAIL) begin
                // R15 inverted remainder, low bit first
                dl_data_q <= ~crc_d[0];
            end else begin
                dl_data_q <= msg_q[1];
            end
        end
    end

    // R8 modulo-four sequence count per report
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            seq_q <= 2'h0;
            last_crc_q <= 9'h000;
        end else if (start) begin
            seq_q <= seq_q + 2'h1;
            last_crc_q <= crc_count;
        end
    end

endmodule

// ---- src/prm_defs.vh ----
// Constants shared by the performance report message generator files
`ifndef PRM_DEFS_VH
`define PRM_DEFS_VH

// ****************************************************************
// Register map (word index, byte address is four times the index)
// ****************************************************************
`define PRM_CTRL_INDEX 12'h07f
`define PRM_STAT_INDEX 12'h080
`define PRM_CTRL_ADDR 12'h1fc
`define PRM_STAT_ADDR 12'h200
`define PRM_CTRL_RESET 6'h00

// ****************************************************************
// Control register fields
// ****************************************************************
`define PRM_CTRL_EN_BIT 0
`define PRM_CTRL_CR_BIT 1
`define PRM_CTRL_R_BIT 2
`define PRM_CTRL_U1_BIT 3
`define PRM_CTRL_U2_BIT 4
`define PRM_CTRL_LB_BIT 5

// ****************************************************************
// Timing
// ****************************************************************
// One second of the 20 MHz register clock, sized to the second counter
`define PRM_SECOND_CYCLES 25'h131_2d00

// ****************************************************************
// Message layout
// ****************************************************************
`define PRM_FLAG 8'h7e
`define PRM_ADDR_HI 6'h0e
`define PRM_TEI 8'h01
`define PRM_CONTROL 8'h03
`define PRM_FCS_FIRST 7'h08
`define PRM_FCS_TAIL 7'h60
`define PRM_LAST_BIT 7'h6f
`define PRM_BIT_ONE 7'h01

// ****************************************************************
// CRC-6 grade limits and frame check sequence
// ****************************************************************
`define PRM_CRC_ONE 9'h001
`define PRM_CRC_FIVE 9'h005
`define PRM_CRC_TEN 9'h00a
`define PRM_CRC_HUNDRED 9'h064
`define PRM_CRC_319 9'h13f
`define PRM_CRC_320 9'h140
`define PRM_CRC_MAX 9'h1ff
`define PRM_FCS_INIT 16'hffff
`define PRM_FCS_POLY 16'h8408

`endif

// ---- src/prm_evt_count.v ----
// Per-second event counters: saturating CRC-6 count and sticky event flags
`timescale 1ns/1ps
`include "prm_defs.vh"

module prm_evt_count (
    input wire pclk,
    input wire presetn,
    input wire clear,
    input wire evt_crc,
    input wire [3:0] evt_flag,
    output reg [8:0] crc_count_q,
    output reg [3:0] flag_q
);

    // R3 crc count
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            crc_count_q <= 9'h000;
        end else if (clear) begin
            // R14 restart interval; an event on the boundary opens the new second
            crc_count_q <= evt_crc ? `PRM_CRC_ONE : 9'h000;
        end else if (evt_crc && crc_count_q != `PRM_CRC_MAX) begin
            crc_count_q <= crc_count_q + `PRM_CRC_ONE;
        end
    end

    genvar i;
    generate
        for (i = 0; i < 4; i = i + 1) begin : g_flag
            // R3 sticky event flags
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    flag_q[i] <= 1'b0;
                end else if (clear) begin
                    flag_q[i] <= evt_flag[i];
                end else begin
                    flag_q[i] <= flag_q[i] | evt_flag[i];
                end
            end
        end
    endgenerate

endmodule

// ---- src/prm_fcs16.v ----
// Serial 16-bit frame check sequence, reflected, LSB first
`timescale 1ns/1ps
`include "prm_defs.vh"

module prm_fcs16 (
    input wire pclk,
    input wire presetn,
    input wire init,
    input wire step,
    input wire tail,
    input wire din,
    output reg [15:0] crc_d,
    output reg [15:0] crc_q
);

    reg fb;

    // R15 check sequence update
    always @* begin
        fb = din ^ crc_q[0];
        crc_d = crc_q;
        if (init) begin
            crc_d = `PRM_FCS_INIT;
        end else if (step && tail) begin
            // Shift the remainder out; ones fill so the sent inverse is clean
            crc_d = {1'b1, crc_q[15:1]};
        end else if (step) begin
            crc_d = {1'b0, crc_q[15:1]} ^ (fb ? `PRM_FCS_POLY : 16'h0000);
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            crc_q <= `PRM_FCS_INIT;
        end else begin
            crc_q <= crc_d;
        end
    end

endmodule

// ---- testbench/prmg_monitor.sv ----
// Port checker for the report generator
`timescale 1ns/1ps
`include "prm_defs.vh"
module prmg_monitor #(
    parameter [24:0] SECOND_CYCLES = 25'h190
) (
    input logic pclk,
    input logic presetn,
    input logic psel,
    input logic penable,
    input logic pwrite,
    input logic [11:0] paddr,
    input logic [31:0] pwdata,
    input logic pready,
    input logic pslverr,
    input logic [31:0] prdata_q,
    input logic t1_mode,
    input logic esf_mode,
    input logic data_link_slot,
    input logic evt_line_viol,
    input logic evt_crc,
    input logic evt_frame_bit,
    input logic evt_severe_frame,
    input logic evt_slip,
    input logic dl_active,
    input logic dl_data_q
);
    logic [6:0] bit_cnt_q;
    logic [31:0] cyc_q;
    logic en_q;
    wire mode_ok = t1_mode && esf_mode;
    // Enable shadow, free cycle count, bits consumed in this report
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bit_cnt_q <= 7'h00;
            cyc_q <= 32'h0000_0000;
            en_q <= 1'b0;
        end else begin
            bit_cnt_q <= dl_active ? bit_cnt_q + {6'h00, data_link_slot} : 7'h00;
            cyc_q <= cyc_q + 32'h0000_0001;
            if (psel && penable && pwrite && paddr == `PRM_CTRL_ADDR) begin
                en_q <= pwdata[0];
            end
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_mode_gate: assert property (!mode_ok |=> !dl_active)
        else $error("report outside ESF");
    a_start_cause: assert property ($rose(dl_active) |-> $past(mode_ok && en_q))
        else $error("start not enabled");
    a_second_pace: assert property ($rose(dl_active) |-> cyc_q % SECOND_CYCLES == 0)
        else $error("start off second");
    a_flag_bits: assert property (dl_active && bit_cnt_q < 7'h08 |->
        dl_data_q == ((`PRM_FLAG >> bit_cnt_q[2:0]) & 8'h01)) else $error("flag bit");
    a_bit_hold: assert property (dl_active && !data_link_slot |=>
        !dl_active || $stable(dl_data_q)) else $error("bit moved");
    a_idle_low: assert property (!dl_active |-> !dl_data_q) else $error("idle bit");
    a_frame_len: assert property ($fell(dl_active) && $past(mode_ok) |->
        bit_cnt_q == 7'h70) else $error("length");
    a_bad_addr: assert property (psel && penable && paddr != `PRM_CTRL_ADDR &&
        paddr != `PRM_STAT_ADDR |-> pslverr) else $error("no slave error");
    c_report: cover property ($fell(dl_active) && bit_cnt_q == 7'h70);
    c_unmapped: cover property (pslverr);
    c_slow_slot: cover property (dl_active && !data_link_slot);
endmodule
bind prm_gen prmg_monitor #(.SECOND_CYCLES(SECOND_CYCLES)) u_prmg_monitor (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata_q(prdata_q),
    .t1_mode(t1_mode), .esf_mode(esf_mode), .data_link_slot(data_link_slot),
    .evt_line_viol(evt_line_viol), .evt_crc(evt_crc), .evt_frame_bit(evt_frame_bit),
    .evt_severe_frame(evt_severe_frame), .evt_slip(evt_slip), .dl_active(dl_active),
    .dl_data_q(dl_data_q));

// ---- testbench/prmg_far_end.sv ----
// Far-end data-link receiver: paces slots and collects report bits
`timescale 1ns/1ps
module prmg_far_end (
    input logic pclk,
    input logic presetn,
    input logic slow,
    input logic dl_active,
    input logic dl_data_q,
    output logic data_link_slot,
    output logic [111:0] msg_q
);
    logic [1:0] div_q;
    // Slots run free; slow mode spaces them to stress bit holding
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_q <= 2'h0;
            data_link_slot <= 1'b0;
            msg_q <= 112'h0;
        end else begin
            div_q <= (div_q == 2'h2) ? 2'h0 : div_q + 2'h1;
            data_link_slot <= !slow || div_q == 2'h0;
            if (data_link_slot && dl_active) begin
                msg_q <= {dl_data_q, msg_q[111:1]};
            end
        end
    end
endmodule

// ---- testbench/perf_report_message_gen_tb.sv ----
// Self-checking bench for the report generator
`timescale 1ns/1ps
`include "prm_defs.vh"
module perf_report_message_gen_tb;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic t1_mode = 1'b1, esf_mode = 1'b1, slow = 1'b0, evt_crc = 1'b0, er;
    logic evt_line_viol = 1'b0, evt_frame_bit = 1'b0, evt_severe_frame = 1'b0, evt_slip = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, rd;
    logic [8:0] pn = 9'h000;
    logic [3:0] pf = 4'h0;
    logic [5:0] pc = 6'h2b;
    logic [1:0] seq = 2'h0;
    logic [8:0] crc_tbl [12] = '{9'h001, 9'h002, 9'h005, 9'h006, 9'h00a, 9'h00b, 9'h064,
        9'h065, 9'h13f, 9'h140, 9'h141, 9'h000};
    wire pready, pslverr, dl_active, dl_data_q, data_link_slot;
    wire [31:0] prdata_q;
    wire [111:0] msg_q;
    int n_errors = 0, check_count = 0;
    always #25 pclk = ~pclk;
    prm_gen #(.SECOND_CYCLES(25'h190)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .pslverr(pslverr), .prdata_q(prdata_q), .t1_mode(t1_mode), .esf_mode(esf_mode),
        .data_link_slot(data_link_slot), .evt_line_viol(evt_line_viol), .evt_crc(evt_crc),
        .evt_frame_bit(evt_frame_bit), .evt_severe_frame(evt_severe_frame),
        .evt_slip(evt_slip), .dl_active(dl_active), .dl_data_q(dl_data_q));
    prmg_far_end i_far (.pclk(pclk), .presetn(presetn), .slow(slow), .dl_active(dl_active),
        .dl_data_q(dl_data_q), .data_link_slot(data_link_slot), .msg_q(msg_q));
    task automatic check(input logic [111:0] seen, input logic [111:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata_q;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Whole report as sent, octet one in the low bits
    function automatic logic [111:0] exp_msg(input logic [8:0] n, input logic [3:0] f,
        input logic [5:0] c, input logic [1:0] s);
        logic [111:0] m;
        logic [15:0] r;
        logic [7:0] od, ev;
        od = {n > 9'h005 && n <= 9'h00a, f[0], n > 9'h00a && n <= 9'h064, c[3], c[4],
            n > 9'h064 && n <= 9'h13f, f[3], n > 9'h140};
        ev = {f[1], f[2], c[5], n == 9'h001, c[2], n > 9'h001 && n <= 9'h005, s};
        m = {16'h0000, {4{ev, od}}, 8'h03, 8'h01, 6'h0e, c[1], 1'b0, 8'h7e};
        r = 16'hffff;
        for (int b = 8; b < 96; b++) begin
            r = (r >> 1) ^ ((r[0] ^ m[b]) ? 16'h8408 : 16'h0000);
        end
        m[111:96] = ~r;
        return m;
    endfunction
    // Sends events into the second whose report follows the one now starting
    task automatic round(input logic [8:0] n, input logic [3:0] f, input logic [5:0] c);
        do @(posedge pclk); while (dl_active !== 1'b1);
        for (int i = 0; i <= n; i++) begin
            @(posedge pclk);
            evt_crc <= i < n;
            {evt_slip, evt_severe_frame, evt_frame_bit, evt_line_viol} <= (i == 0) ? f : 4'h0;
        end
        // A count of zero leaves the loop with the event flags still raised
        @(posedge pclk);
        {evt_slip, evt_severe_frame, evt_frame_bit, evt_line_viol} <= 4'h0;
        while (dl_active !== 1'b0) @(posedge pclk);
        check(msg_q, exp_msg(pn, pf, pc, seq));
        seq++;
        apb(1'b0, `PRM_STAT_ADDR, 32'h0000_0000);
        check(rd, {20'h0_0000, seq, 1'b0, pn});
        apb(1'b1, `PRM_CTRL_ADDR, {26'h000_0000, c});
        pn = n;
        pf = f;
        pc = c;
    endtask
    task automatic reg_access;
        apb(1'b0, `PRM_CTRL_ADDR, 32'h0000_0000);
        check(rd, 32'h0000_0000);
        apb(1'b1, `PRM_CTRL_ADDR, 32'hffff_ffeb);
        apb(1'b0, `PRM_CTRL_ADDR, 32'h0000_0000);
        check(rd, 32'h0000_002b);
        apb(1'b0, 12'h010, 32'h0000_0000);
        check({er, rd}, 33'h1_0000_0000);
    endtask
    task automatic grade_sweep;
        for (int i = 0; i < 12; i++) begin
            slow <= i[0];
            round(crc_tbl[i], i[3:0] + 4'h1, i[0] ? 6'h15 : 6'h2b);
        end
        round(9'h000, 4'h0, 6'h2b);
    endtask
    // Enable is written before the modes so no tick sneaks in between
    task automatic mode_gate;
        int hits;
        logic prev;
        // A report in flight is dropped once the framing goes away
        do @(posedge pclk); while (dl_active !== 1'b1);
        t1_mode <= 1'b0;
        repeat (2) @(posedge pclk);
        check(dl_active, 1'b0);
        check(dl_data_q, 1'b0);
        for (int k = 0; k < 3; k++) begin
            hits = 0;
            apb(1'b1, `PRM_CTRL_ADDR, {26'h000_0000, 5'h15, k != 2});
            t1_mode <= k != 0;
            esf_mode <= k != 1;
            @(posedge pclk);
            prev = dl_active;
            repeat (450) begin
                @(posedge pclk);
                hits += dl_active && !prev;
                prev = dl_active;
            end
            check(hits, 0);
        end
    endtask
    task automatic report_and_stop;
        if (n_errors == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        reg_access;
        grade_sweep;
        mode_gate;
        report_and_stop;
    end
    initial begin
        repeat (20000) @(posedge pclk);
        n_errors++;
        report_and_stop;
    end
endmodule
